// ===== rtl/power_down_pkg.sv
// power_down_pkg: shared constants and types of the power-down controller
// assumes: 32-bit apb register bus, single 10 MHz core clock
package power_down_pkg;

	// ==========================================================
	// bus geometry
	localparam int ADDR_W = 32;                  // apb address width
	localparam int DATA_W = 32;                  // apb data width
	localparam int LVL_W  = 4;                   // interrupt level width

	// ==========================================================
	// register map
	localparam logic [31:0] STANDBY_CONTROL_ADDR = 32'hffff8614;
	localparam logic [31:0] POWER_STATE_ADDR     = 32'hffff8618;

	// ==========================================================
	// standby_control layout
	localparam int          DEEP_STOP_BIT   = 7; // sleep picks standby
	localparam int          PIN_FLOAT_BIT   = 6; // ports float in standby
	localparam int          ZERO_RSV_BIT    = 5; // reserved, reads 0
	localparam logic [4:0]  ONES_RSV_VALUE  = 5'h1f; // bits 4..0 read 1
	localparam logic [7:0]  STANDBY_CONTROL_RESET = 8'h1f;

	// ==========================================================
	// power_state layout
	localparam int POWER_STATE_SLEEP_BIT   = 0;  // in sleep
	localparam int POWER_STATE_STANDBY_BIT = 1;  // in standby

	// ==========================================================
	// operating modes
	typedef enum logic [1:0] {
		MODE_RUN,
		MODE_SLEEP,
		MODE_STANDBY
	} pd_mode_t;

endpackage

// ===== rtl/wake_filter.sv
// wake_filter: decides which events may end sleep mode
// assumes: all inputs synchronous to core_clk, levels from intc and dma
`timescale 1ns/100ps
module wake_filter
	import power_down_pkg::*;
(
	input  wire logic                            irqPending,
	input  wire logic                            irqSourceEnable,
	input  wire logic [power_down_pkg::LVL_W-1:0] irqLevel,
	input  wire logic [power_down_pkg::LVL_W-1:0] cpuMaskLevel,
	input  wire logic                            memXferAddrErr,
	input  wire logic                            dataXferAddrErr,
	output      logic                            irqAccept,
	output      logic                            addrErr
);

	// ==========================================================
	// acceptance
	// only a request above the status-word mask and enabled at
	// its source may wake the cpu
	always_comb begin
		irqAccept = irqPending && irqSourceEnable &&
			(irqLevel > cpuMaskLevel);
		addrErr = memXferAddrErr || dataXferAddrErr;
	end

endmodule // wake_filter

// ===== rtl/power_down_mode_control.sv
// power_down_mode_control: sleep and standby sequencing with apb register
// assumes: apb master on core_clk, reset pins already synchronous
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
module power_down_mode_control (
	input  wire logic                             core_clk,
	input  wire logic                             rst_n,
	// apb slave
	input  wire logic                             psel,
	input  wire logic                             penable,
	input  wire logic                             pwrite,
	input  wire logic [power_down_pkg::ADDR_W-1:0] paddr,
	input  wire logic [power_down_pkg::DATA_W-1:0] pwdata,
	input  wire logic [3:0]                       pstrb,
	output      logic [power_down_pkg::DATA_W-1:0] prdata,
	output      logic                             pready,
	output      logic                             pslverr,
	// reset pins
	input  wire logic                             power_on_reset_n,
	input  wire logic                             manual_reset_n,
	// cpu, watchdog and interrupt side
	input  wire logic                             sleepExec,
	input  wire logic                             watchdog_run_enable,
	input  wire logic                             irqPending,
	input  wire logic                             irqSourceEnable,
	input  wire logic [power_down_pkg::LVL_W-1:0] irqLevel,
	input  wire logic [power_down_pkg::LVL_W-1:0] cpuMaskLevel,
	input  wire logic                             memXferAddrErr,
	input  wire logic                             dataXferAddrErr,
	// power controls
	output      logic                             cpuHalt,
	output      logic                             clockRun,
	output      logic                             periphRun,
	output      logic                             portFloat,
	output      logic                             wakeIrq,
	output      logic                             wakeAddrErr
);
	import power_down_pkg::*;

	// ==========================================================
	// state
	typedef struct packed {
		pd_mode_t    mode;      // current operating mode
		logic        deepStop;  // deep_stop_select
		logic        pinFloat;  // pin_float_select
		logic [31:0] rdata;     // read data for access phase
		logic        errResp;   // slave error for access phase
		logic        wakeIrq;   // interrupt exception start pulse
		logic        wakeErr;   // address error exception start pulse
	} state_t;

	state_t state_r;            // registered state
	state_t state_nxt;          // next state

	logic irqAccept;            // interrupt may wake cpu
	logic addrErr;              // transfer address error seen
	logic setupPhase;           // apb setup cycle
	logic accessPhase;          // apb access cycle
	logic hitControl;           // address hits standby_control
	logic hitState;             // address hits power_state
	logic [7:0] controlView;    // standby_control as read

	// ==========================================================
	// wake source filtering
	wake_filter u_wake (
		.irqPending      (irqPending),
		.irqSourceEnable (irqSourceEnable),
		.irqLevel        (irqLevel),
		.cpuMaskLevel    (cpuMaskLevel),
		.memXferAddrErr  (memXferAddrErr),
		.dataXferAddrErr (dataXferAddrErr),
		.irqAccept       (irqAccept),
		.addrErr         (addrErr)
	);

	// ==========================================================
	// bus decode
	// answer without wait states, read data prepared in setup
	always_comb begin
		setupPhase  = psel && !penable;
		accessPhase = psel && penable;
		hitControl  = (paddr == STANDBY_CONTROL_ADDR);
		hitState    = (paddr == POWER_STATE_ADDR);
		// reserved bits fixed on read
		controlView = {state_r.deepStop, state_r.pinFloat, 1'b0,
			ONES_RSV_VALUE};
	end

	// ==========================================================
	// next state
	always_comb begin
		state_nxt         = state_r;
		state_nxt.wakeIrq = 1'b0;
		state_nxt.wakeErr = 1'b0;

		// read data and error captured in the setup cycle
		if (setupPhase) begin
			state_nxt.rdata   = 32'h0000_0000;
			state_nxt.errResp = !(hitControl || hitState);
			if (hitControl && !pwrite) begin
				state_nxt.rdata = {24'h00_0000, controlView};
			end else if (hitState && !pwrite) begin
				state_nxt.rdata[POWER_STATE_SLEEP_BIT] =
					(state_r.mode == MODE_SLEEP);
				state_nxt.rdata[POWER_STATE_STANDBY_BIT] =
					(state_r.mode == MODE_STANDBY);
			end
		end

		// register write on the access edge, low byte lane only
		if (accessPhase && pwrite && hitControl && pstrb[0]) begin
			// clearing always allowed, setting blocked by watchdog
			if (!pwdata[DEEP_STOP_BIT] || !watchdog_run_enable) begin
				state_nxt.deepStop = pwdata[DEEP_STOP_BIT];
			end
			if (!pwdata[PIN_FLOAT_BIT] || !watchdog_run_enable) begin
				state_nxt.pinFloat = pwdata[PIN_FLOAT_BIT];
			end
		end

		// mode sequencing
		case (state_r.mode)
			MODE_RUN: begin
				// halt once the sleep instruction completes
				if (sleepExec) begin
					if (state_r.deepStop) begin
						state_nxt.mode = MODE_STANDBY;
					end else begin
						state_nxt.mode = MODE_SLEEP;
					end
				end
			end
			MODE_SLEEP: begin
				// address error outranks an interrupt
				if (addrErr) begin
					state_nxt.mode    = MODE_RUN;
					state_nxt.wakeErr = 1'b1;
				end else if (irqAccept) begin
					state_nxt.mode    = MODE_RUN;
					state_nxt.wakeIrq = 1'b1;
				end
			end
			MODE_STANDBY: begin
				// nothing but power-on reset leaves here
				state_nxt.mode = MODE_STANDBY;
			end
			default: begin
				state_nxt.mode = MODE_RUN;
			end
		endcase

		// manual reset: ends sleep, ignored in standby
		if (!manual_reset_n && (state_r.mode != MODE_STANDBY)) begin
			state_nxt.mode     = MODE_RUN;
			state_nxt.deepStop = 1'b0;
			state_nxt.pinFloat = 1'b0;
			state_nxt.wakeIrq  = 1'b0;
			state_nxt.wakeErr  = 1'b0;
		end

		// power-on reset wins over everything
		if (!power_on_reset_n) begin
			state_nxt.mode     = MODE_RUN;
			state_nxt.deepStop = STANDBY_CONTROL_RESET[DEEP_STOP_BIT];
			state_nxt.pinFloat = STANDBY_CONTROL_RESET[PIN_FLOAT_BIT];
			state_nxt.wakeIrq  = 1'b0;
			state_nxt.wakeErr  = 1'b0;
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r.mode     <= MODE_RUN;
			state_r.deepStop <= STANDBY_CONTROL_RESET[DEEP_STOP_BIT];
			state_r.pinFloat <= STANDBY_CONTROL_RESET[PIN_FLOAT_BIT];
			state_r.rdata    <= 32'h0000_0000;
			state_r.errResp  <= 1'b0;
			state_r.wakeIrq  <= 1'b0;
			state_r.wakeErr  <= 1'b0;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ==========================================================
	// outputs
	always_comb begin
		prdata      = state_r.rdata;
		pready      = 1'b1;
		pslverr     = accessPhase && state_r.errResp;
		// cpu stops in both power-down modes, registers untouched
		cpuHalt     = (state_r.mode != MODE_RUN);
		// clock and peripherals stop only in standby
		clockRun    = (state_r.mode != MODE_STANDBY);
		periphRun   = (state_r.mode != MODE_STANDBY);
		portFloat   = (state_r.mode == MODE_STANDBY) &&
			state_r.pinFloat;
		wakeIrq     = state_r.wakeIrq;
		wakeAddrErr = state_r.wakeErr;
	end

	// ==========================================================
	// checks
	sequence s_resetsHigh;
		power_on_reset_n && manual_reset_n;
	endsequence

	sequence s_inSleep;
		cpuHalt && clockRun;
	endsequence

	sequence s_sleepRequest;
		(!cpuHalt && sleepExec) and s_resetsHigh;
	endsequence

	property p_sleepEntry;
		@(posedge core_clk) disable iff (!rst_n)
		s_sleepRequest and !state_r.deepStop |=>
			s_inSleep ##1 (periphRun || !cpuHalt);
	endproperty
	a_sleepEntry: assert property (p_sleepEntry)
		else $error("sleep not entered");

	property p_sleepRuns;
		@(posedge core_clk) disable iff (!rst_n)
		state_r.mode == MODE_SLEEP |-> cpuHalt && periphRun && clockRun;
	endproperty
	a_sleepRuns: assert property (p_sleepRuns)
		else $error("peripherals stopped in sleep");

	property p_standbyEntry;
		@(posedge core_clk) disable iff (!rst_n)
		s_sleepRequest and state_r.deepStop |=>
			cpuHalt && !clockRun && !periphRun;
	endproperty
	a_standbyEntry: assert property (p_standbyEntry)
		else $error("standby not entered");

	property p_guardSet;
		@(posedge core_clk) disable iff (!rst_n)
		accessPhase && pwrite && hitControl && watchdog_run_enable &&
			!state_r.deepStop && !state_r.pinFloat |=>
			!state_r.deepStop && !state_r.pinFloat;
	endproperty
	a_guardSet: assert property (p_guardSet)
		else $error("mode bit set while watchdog runs");

	property p_floatPorts;
		@(posedge core_clk) disable iff (!rst_n)
		portFloat |-> !clockRun && state_r.pinFloat;
	endproperty
	a_floatPorts: assert property (p_floatPorts)
		else $error("ports float outside standby");

	property p_reservedRead;
		@(posedge core_clk) disable iff (!rst_n)
		setupPhase && hitControl && !pwrite |=>
			prdata[ZERO_RSV_BIT] == 1'b0 && prdata[4:0] == ONES_RSV_VALUE;
	endproperty
	a_reservedRead: assert property (p_reservedRead)
		else $error("reserved bits read wrong");

	property p_irqWake;
		@(posedge core_clk) disable iff (!rst_n)
		// a manual reset in the same cycle outranks the wake
		(state_r.mode == MODE_SLEEP && irqAccept && !addrErr) and
			s_resetsHigh |=> !cpuHalt && wakeIrq ##1 !wakeIrq;
	endproperty
	a_irqWake: assert property (p_irqWake)
		else $error("interrupt did not end sleep");

	property p_sleepHolds;
		@(posedge core_clk) disable iff (!rst_n)
		(state_r.mode == MODE_SLEEP && !irqAccept && !addrErr) and
			s_resetsHigh |=> s_inSleep;
	endproperty
	a_sleepHolds: assert property (p_sleepHolds)
		else $error("sleep ended without cause");

	property p_errWake;
		@(posedge core_clk) disable iff (!rst_n)
		(state_r.mode == MODE_SLEEP && addrErr) and s_resetsHigh |=>
			!cpuHalt && wakeAddrErr && !wakeIrq;
	endproperty
	a_errWake: assert property (p_errWake)
		else $error("address error did not end sleep");

	property p_porWake;
		@(posedge core_clk) disable iff (!rst_n)
		!power_on_reset_n |=> !cpuHalt && !state_r.deepStop;
	endproperty
	a_porWake: assert property (p_porWake)
		else $error("power-on reset did not wake");

	property p_standbyHolds;
		@(posedge core_clk) disable iff (!rst_n)
		!clockRun && power_on_reset_n |=> !clockRun && !wakeIrq;
	endproperty
	a_standbyHolds: assert property (p_standbyHolds)
		else $error("standby left without power-on reset");

endmodule // power_down_mode_control

// ===== bench/cpu_side_model.sv
// cpu_side_model: cpu core and watchdog as seen by the power-down block
// assumes: bench requests sleep and watchdog state by levels on core_clk
`timescale 1ns/100ps
module cpu_side_model (
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic sleepReq,
	input  wire logic wdReq,
	input  wire logic cpuHalt,
	output      logic sleepExec,
	output      logic watchdog_run_enable
);
	// ==========================================================
	// sleep completion pulse and watchdog run level
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sleepExec           <= 1'b0;
			watchdog_run_enable <= 1'b0;
		end else begin
			// a halted cpu executes nothing, one pulse per request
			sleepExec <= sleepReq & ~cpuHalt & ~sleepExec;
			// watchdog level follows wdReq one cycle late, mode bit writes may come while it runs
			watchdog_run_enable <= wdReq;
		end
	end
endmodule // cpu_side_model

// ===== bench/power_down_mode_control_tb.sv
// power_down_mode_control_tb: self-checking bench of the power-down block
// assumes: cpu_side_model beside the design, apb master in this module
`timescale 1ns/100ps
module power_down_mode_control_tb;
	import power_down_pkg::*;
	// ==========================================================
	// signals
	logic        core_clk, rst_n, psel, penable, pwrite;
	logic [31:0] paddr, pwdata, prdata, rdVal;
	logic        pready, pslverr, slvErr;
	logic        power_on_reset_n, manual_reset_n, sleepExec, wdRun;
	logic        sleepReq, wdReq, irqPending, irqSourceEnable;
	logic [3:0]  irqLevel, cpuMaskLevel;
	logic        memXferAddrErr, dataXferAddrErr;
	logic        cpuHalt, clockRun, periphRun, portFloat;
	logic        wakeIrq, wakeAddrErr;
	int          err_total, cmp_count;

	initial core_clk = 1'b0;
	always #50 core_clk = ~core_clk; // 10 MHz

	power_down_mode_control DUT (.core_clk(core_clk), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .power_on_reset_n(power_on_reset_n),
		.manual_reset_n(manual_reset_n), .sleepExec(sleepExec),
		.watchdog_run_enable(wdRun), .irqPending(irqPending),
		.irqSourceEnable(irqSourceEnable), .irqLevel(irqLevel),
		.cpuMaskLevel(cpuMaskLevel), .memXferAddrErr(memXferAddrErr),
		.dataXferAddrErr(dataXferAddrErr), .cpuHalt(cpuHalt),
		.clockRun(clockRun), .periphRun(periphRun), .portFloat(portFloat),
		.wakeIrq(wakeIrq), .wakeAddrErr(wakeAddrErr));

	cpu_side_model cpu (.core_clk(core_clk), .rst_n(rst_n),
		.sleepReq(sleepReq), .wdReq(wdReq), .cpuHalt(cpuHalt),
		.sleepExec(sleepExec), .watchdog_run_enable(wdRun));

	// ==========================================================
	// helpers
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one apb transfer, held until pready at a rising edge
	task automatic apb(input logic w, input logic [31:0] a,
		input logic [31:0] d);
		@(posedge core_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1) @(posedge core_clk);
		rdVal = prdata;
		slvErr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// request sleep, look once the halt has landed
	task automatic sleepNow();
		@(posedge core_clk);
		sleepReq <= 1'b1;
		@(posedge core_clk);
		sleepReq <= 1'b0;
		@(posedge core_clk);
		@(negedge core_clk);
	endtask

	// one-cycle wake cause: bit0 irq, bit1 mem error, bit2 data error
	task automatic pulseIn(input logic [2:0] v);
		@(posedge core_clk);
		irqPending      <= v[0];
		memXferAddrErr  <= v[1];
		dataXferAddrErr <= v[2];
		@(posedge core_clk);
		{dataXferAddrErr, memXferAddrErr, irqPending} <= 3'h0;
		@(negedge core_clk);
	endtask

	// one-cycle reset pin pulse: por high picks power-on reset
	task automatic rstPulse(input logic por);
		@(posedge core_clk);
		if (por) power_on_reset_n <= 1'b0;
		else manual_reset_n <= 1'b0;
		@(posedge core_clk);
		{power_on_reset_n, manual_reset_n} <= 2'h3;
		@(negedge core_clk);
	endtask

	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// ==========================================================
	// scenarios
	task automatic tRegs();
		apb(0, STANDBY_CONTROL_ADDR, 0);
		chk("ctrl reset", 32'h1f, rdVal);
		wdReq <= 1'b1;
		apb(1, STANDBY_CONTROL_ADDR, 32'hdf);
		apb(0, STANDBY_CONTROL_ADDR, 0);
		chk("ctrl locked", 32'h1f, rdVal);
		wdReq <= 1'b0;
		apb(1, STANDBY_CONTROL_ADDR, 32'hdf);
		apb(0, STANDBY_CONTROL_ADDR, 0);
		chk("ctrl set", 32'hdf, rdVal);
		chk("mapped ok", 0, slvErr);
		apb(1, STANDBY_CONTROL_ADDR, 32'h1f);
		apb(0, 32'hffff8620, 0);
		chk("unmapped", 1, slvErr);
		chk("unmapped data", 0, rdVal);
		$display("test regs done");
	endtask

	task automatic tSleep();
		{irqSourceEnable, irqLevel, cpuMaskLevel} <= {1'b1, 4'h3, 4'h3};
		sleepNow();
		chk("halt", 1, cpuHalt);
		chk("clk run", 1, clockRun);
		chk("periph run", 1, periphRun);
		apb(0, POWER_STATE_ADDR, 0);
		chk("state sleep", 1, rdVal);
		pulseIn(3'h1);
		chk("mask keeps", 1, cpuHalt);
		@(posedge core_clk);
		{irqSourceEnable, irqLevel} <= {1'b0, 4'h5};
		pulseIn(3'h1);
		chk("source off keeps", 1, cpuHalt);
		@(posedge core_clk);
		{irqSourceEnable, irqLevel} <= {1'b1, 4'h4};
		pulseIn(3'h1);
		chk("wake irq", 1, wakeIrq);
		chk("irq halt", 0, cpuHalt);
		for (int i = 1; i < 3; i++) begin
			sleepNow();
			pulseIn(3'(1 << i));
			chk("wake err", 1, wakeAddrErr);
			chk("err halt", 0, cpuHalt);
		end
		sleepNow();
		rstPulse(1'b0);
		chk("manual halt", 0, cpuHalt);
		sleepNow();
		rstPulse(1'b1);
		chk("por halt", 0, cpuHalt);
		$display("test sleep done");
	endtask

	task automatic tStandby();
		apb(1, STANDBY_CONTROL_ADDR, 32'h9f);
		sleepNow();
		chk("hold pins", 0, portFloat);
		rstPulse(1'b1);
		apb(1, STANDBY_CONTROL_ADDR, 32'hdf);
		sleepNow();
		chk("sby halt", 1, cpuHalt);
		chk("sby clk", 0, clockRun);
		chk("sby periph", 0, periphRun);
		chk("float", 1, portFloat);
		apb(0, POWER_STATE_ADDR, 0);
		chk("state sby", 2, rdVal);
		for (int i = 0; i < 3; i++) begin
			pulseIn(3'(1 << i));
			chk("sby stays", 1, cpuHalt);
		end
		rstPulse(1'b0);
		chk("sby manual", 0, clockRun);
		rstPulse(1'b1);
		chk("por clk", 1, clockRun);
		chk("por halt", 0, cpuHalt);
		apb(0, STANDBY_CONTROL_ADDR, 0);
		chk("ctrl after por", 32'h1f, rdVal);
		$display("test standby done");
	endtask

	// ==========================================================
	// main sequence and watchdog
	initial begin
		{rst_n, psel, penable, pwrite, sleepReq, wdReq} = 6'h0;
		{paddr, pwdata} = 64'h0;
		{power_on_reset_n, manual_reset_n} = 2'h3;
		{irqPending, irqSourceEnable, memXferAddrErr} = 3'h0;
		{dataXferAddrErr, irqLevel, cpuMaskLevel} = 9'h0;
		err_total = 0;
		cmp_count = 0;
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		tRegs();
		tSleep();
		tStandby();
		results();
	end

	initial begin
		repeat (3000) @(posedge core_clk);
		err_total++;
		$display("watchdog expired");
		results();
	end
endmodule // power_down_mode_control_tb
